// file: rtl/wsctx_consts.vh
`ifndef WSCTX_CONSTS_VH
`define WSCTX_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define REG_WORKSPACE_BASE 5'h00
`define REG_PROGRAM_COUNTER 5'h04
`define REG_STATUS_FLAGS_MASK 5'h08
`define REG_COMMAND 5'h0c
`define REG_ARGUMENT 5'h10
`define REG_RESULT 5'h14
`define REG_ENGINE_STATE 5'h18

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_WORKSPACE_BASE 16'h0000
`define RST_PROGRAM_COUNTER 16'h0000
`define RST_STATUS_FLAGS_MASK 16'h0000

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CMD_OP_MSB 3
`define CMD_OP_LSB 0
`define CMD_REG_MSB 7
`define CMD_REG_LSB 4
`define MASK_MSB 3
`define MASK_LSB 0
`define FLAGS_MSB 15
`define FLAGS_LSB 4
`define SHIFT_MSB 3
`define SHIFT_LSB 0
`define IO_BASE_MSB 12
`define IO_BASE_LSB 1

// ------------------------------------------------------------
// Dedicated workspace register numbers
// ------------------------------------------------------------
`define WR_SHIFT 4'h0
`define WR_LINK 4'hb
`define WR_IO_BASE 4'hc
`define WR_OLD_BASE 4'hd
`define WR_OLD_PC 4'he
`define WR_OLD_STATUS 4'hf

// ------------------------------------------------------------
// Commands
// ------------------------------------------------------------
`define OP_WR_READ 4'h0
`define OP_WR_WRITE 4'h1
`define OP_WR_ADDRESS 4'h2
`define OP_SHIFT_COUNT 4'h3
`define OP_IO_BASE 4'h4
`define OP_INDEXED 4'h5
`define OP_BRANCH_LINK 4'h6
`define OP_BRANCH_LOAD_CONTEXT 4'h7
`define OP_INTERRUPT 4'h8
`define OP_RETURN_CONTEXT 4'h9
`define OP_ADVANCE 4'ha
`define OP_LOAD_MASK 4'hb
`define OP_LOAD_FLAGS 4'hc
`define OP_LOAD_RESET 4'hd

// ------------------------------------------------------------
// Program counter increment
// ------------------------------------------------------------
`define PC_STEP 16'h0002

`endif

// file: rtl/workspace_register_context.v
`timescale 1ns/1ps
`include "wsctx_consts.vh"

module workspace_register_context (
   input wire I_CLOCK,
   input wire I_RESET_N,
   input wire [4:0] I_AVS_ADDRESS,
   input wire I_AVS_READ,
   input wire I_AVS_WRITE,
   input wire [31:0] I_AVS_WRITEDATA,
   input wire [3:0] I_AVS_BYTEENABLE,
   output reg [31:0] O_AVS_READDATA,
   output reg O_AVS_WAITREQUEST,
   output reg O_MEM_REQ,
   output reg O_MEM_WE,
   output reg [15:0] O_MEM_ADDR,
   output reg [15:0] O_MEM_WDATA,
   input wire I_MEM_ACK,
   input wire [15:0] I_MEM_RDATA
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function [15:0] wr_address;
      input [15:0] base;
      input [3:0] num;
      begin
         wr_address = base + {11'h000, num, 1'b0};
      end
   endfunction

   function [15:0] merge16;
      input [15:0] old;
      input [15:0] data;
      input [1:0] be;
      begin
         merge16 = {be[1] ? data[15:8] : old[15:8],
                    be[0] ? data[7:0] : old[7:0]};
      end
   endfunction

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   reg rst_meta;
   reg rst_sync;

   always @(posedge I_CLOCK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   reg [15:0] workspace_base;
   reg [15:0] program_counter;
   reg [15:0] status_flags_mask;
   reg [15:0] argument;
   reg [15:0] result;
   reg [15:0] temp_base;
   reg [3:0] op;
   reg [3:0] reg_num;
   reg [2:0] step;
   reg busy;
   reg int_accepted;
   reg int_refused;

   reg plan_acc;
   reg plan_we;
   reg [15:0] plan_addr;
   reg [15:0] plan_wdata;
   reg [31:0] next_readdata;

   wire [3:0] level = argument[`MASK_MSB:`MASK_LSB];
   wire [3:0] mask = status_flags_mask[`MASK_MSB:`MASK_LSB];
   wire is_switch = (op == `OP_BRANCH_LOAD_CONTEXT) ||
                    (op == `OP_INTERRUPT) || (op == `OP_LOAD_RESET);
   // Interrupt vectors are two words each from address zero
   wire [15:0] vector = (op == `OP_INTERRUPT) ?
                        {10'h000, level, 2'b00} : argument;
   wire bus_req = I_AVS_READ | I_AVS_WRITE;
   wire bus_done = bus_req & ~O_AVS_WAITREQUEST;
   wire [15:0] wdata16 = I_AVS_WRITEDATA[15:0];
   wire [1:0] be16 = I_AVS_BYTEENABLE[1:0];

   // ------------------------------------------------------------
   // Memory access plan per command step
   // ------------------------------------------------------------
   always @* begin
      plan_acc = 1'b0;
      plan_we = 1'b0;
      plan_addr = 16'h0000;
      plan_wdata = 16'h0000;
      case (op)
         `OP_WR_READ: begin
            if (step == 3'h0) begin
               plan_acc = 1'b1;
               plan_addr = wr_address(workspace_base, reg_num);
            end
         end
         `OP_WR_WRITE: begin
            if (step == 3'h0) begin
               plan_acc = 1'b1;
               plan_we = 1'b1;
               plan_addr = wr_address(workspace_base, reg_num);
               plan_wdata = argument;
            end
         end
         `OP_SHIFT_COUNT: begin
            if (step == 3'h0) begin
               plan_acc = 1'b1;
               plan_addr = wr_address(workspace_base, `WR_SHIFT);
            end
         end
         `OP_IO_BASE: begin
            if (step == 3'h0) begin
               plan_acc = 1'b1;
               plan_addr = wr_address(workspace_base, `WR_IO_BASE);
            end
         end
         `OP_INDEXED: begin
            if (step == 3'h0 && reg_num != 4'h0) begin
               plan_acc = 1'b1;
               plan_addr = wr_address(workspace_base, reg_num);
            end
         end
         `OP_BRANCH_LINK: begin
            if (step == 3'h0) begin
               plan_acc = 1'b1;
               plan_we = 1'b1;
               plan_addr = wr_address(workspace_base, `WR_LINK);
               plan_wdata = program_counter;
            end
         end
         `OP_BRANCH_LOAD_CONTEXT, `OP_INTERRUPT, `OP_LOAD_RESET: begin
            // Saves go to the new file, addressed through temp_base
            case (step)
               3'h0: begin
                  plan_acc = 1'b1;
                  plan_addr = vector;
               end
               3'h1: begin
                  plan_acc = 1'b1;
                  plan_we = 1'b1;
                  plan_addr = wr_address(temp_base, `WR_OLD_STATUS);
                  plan_wdata = status_flags_mask;
               end
               3'h2: begin
                  plan_acc = 1'b1;
                  plan_we = 1'b1;
                  plan_addr = wr_address(temp_base, `WR_OLD_PC);
                  plan_wdata = program_counter;
               end
               3'h3: begin
                  plan_acc = 1'b1;
                  plan_we = 1'b1;
                  plan_addr = wr_address(temp_base, `WR_OLD_BASE);
                  plan_wdata = workspace_base;
               end
               3'h4: begin
                  plan_acc = 1'b1;
                  plan_addr = vector + `PC_STEP;
               end
               default: begin
                  plan_acc = 1'b0;
               end
            endcase
         end
         `OP_RETURN_CONTEXT: begin
            // Old base is parked in temp_base so all three reads hit
            // the current file
            case (step)
               3'h0: begin
                  plan_acc = 1'b1;
                  plan_addr = wr_address(workspace_base, `WR_OLD_BASE);
               end
               3'h1: begin
                  plan_acc = 1'b1;
                  plan_addr = wr_address(workspace_base, `WR_OLD_PC);
               end
               3'h2: begin
                  plan_acc = 1'b1;
                  plan_addr = wr_address(workspace_base, `WR_OLD_STATUS);
               end
               default: begin
                  plan_acc = 1'b0;
               end
            endcase
         end
         default: begin
            plan_acc = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Register read mux
   // ------------------------------------------------------------
   always @* begin
      next_readdata = 32'h00000000;
      case (I_AVS_ADDRESS)
         `REG_WORKSPACE_BASE: next_readdata = {16'h0000, workspace_base};
         `REG_PROGRAM_COUNTER: next_readdata = {16'h0000, program_counter};
         `REG_STATUS_FLAGS_MASK:
            next_readdata = {16'h0000, status_flags_mask};
         `REG_COMMAND: next_readdata = {24'h000000, reg_num, op};
         `REG_ARGUMENT: next_readdata = {16'h0000, argument};
         `REG_RESULT: next_readdata = {16'h0000, result};
         `REG_ENGINE_STATE:
            next_readdata = {29'h00000000, int_refused, int_accepted, busy};
         default: next_readdata = 32'h00000000;
      endcase
   end

   // ------------------------------------------------------------
   // Bus slave and command engine
   // ------------------------------------------------------------
   always @(posedge I_CLOCK or negedge rst_sync) begin
      if (!rst_sync) begin
         workspace_base <= `RST_WORKSPACE_BASE;
         program_counter <= `RST_PROGRAM_COUNTER;
         status_flags_mask <= `RST_STATUS_FLAGS_MASK;
         argument <= 16'h0000;
         result <= 16'h0000;
         temp_base <= 16'h0000;
         op <= 4'h0;
         reg_num <= 4'h0;
         step <= 3'h0;
         busy <= 1'b0;
         int_accepted <= 1'b0;
         int_refused <= 1'b0;
         O_AVS_READDATA <= 32'h00000000;
         O_AVS_WAITREQUEST <= 1'b1;
         O_MEM_REQ <= 1'b0;
         O_MEM_WE <= 1'b0;
         O_MEM_ADDR <= 16'h0000;
         O_MEM_WDATA <= 16'h0000;
      end else begin
         // Writes stall while a command runs so the engine owns state
         if (bus_req && O_AVS_WAITREQUEST && !(I_AVS_WRITE && busy)) begin
            O_AVS_WAITREQUEST <= 1'b0;
            O_AVS_READDATA <= next_readdata;
         end else begin
            O_AVS_WAITREQUEST <= 1'b1;
         end

         if (bus_done && I_AVS_WRITE) begin
            case (I_AVS_ADDRESS)
               `REG_WORKSPACE_BASE:
                  workspace_base <= merge16(workspace_base, wdata16, be16);
               `REG_PROGRAM_COUNTER:
                  program_counter <= merge16(program_counter, wdata16, be16);
               `REG_STATUS_FLAGS_MASK:
                  status_flags_mask <= merge16(status_flags_mask, wdata16,
                                               be16);
               `REG_ARGUMENT:
                  argument <= merge16(argument, wdata16, be16);
               `REG_COMMAND: begin
                  if (be16[0]) begin
                     op <= wdata16[`CMD_OP_MSB:`CMD_OP_LSB];
                     reg_num <= wdata16[`CMD_REG_MSB:`CMD_REG_LSB];
                     step <= 3'h0;
                     int_accepted <= 1'b0;
                     int_refused <= 1'b0;
                     if (wdata16[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_INTERRUPT &&
                         level > mask) begin
                        int_refused <= 1'b1;
                     end else begin
                        busy <= 1'b1;
                     end
                  end
               end
               default: begin
                  busy <= busy;
               end
            endcase
         end

         if (busy) begin
            if (O_MEM_REQ) begin
               if (I_MEM_ACK) begin
                  O_MEM_REQ <= 1'b0;
                  step <= step + 3'h1;
                  case (op)
                     `OP_WR_READ: result <= I_MEM_RDATA;
                     `OP_SHIFT_COUNT:
                        result <= {12'h000,
                                   I_MEM_RDATA[`SHIFT_MSB:`SHIFT_LSB]};
                     `OP_IO_BASE:
                        result <= {4'h0,
                                   I_MEM_RDATA[`IO_BASE_MSB:`IO_BASE_LSB]};
                     `OP_INDEXED: result <= argument + I_MEM_RDATA;
                     `OP_RETURN_CONTEXT: begin
                        if (step == 3'h0) temp_base <= I_MEM_RDATA;
                        if (step == 3'h1) program_counter <= I_MEM_RDATA;
                        if (step == 3'h2) status_flags_mask <= I_MEM_RDATA;
                     end
                     default: begin
                        if (is_switch) begin
                           if (step == 3'h0) temp_base <= I_MEM_RDATA;
                           if (step == 3'h3) workspace_base <= temp_base;
                           if (step == 3'h4) program_counter <= I_MEM_RDATA;
                        end
                     end
                  endcase
               end
            end else if (plan_acc) begin
               O_MEM_REQ <= 1'b1;
               O_MEM_WE <= plan_we;
               O_MEM_ADDR <= plan_addr;
               O_MEM_WDATA <= plan_wdata;
            end else begin
               busy <= 1'b0;
               case (op)
                  `OP_WR_ADDRESS:
                     result <= wr_address(workspace_base, reg_num);
                  `OP_INDEXED: begin
                     if (reg_num == 4'h0) result <= argument;
                  end
                  `OP_BRANCH_LINK: program_counter <= argument;
                  `OP_RETURN_CONTEXT: workspace_base <= temp_base;
                  `OP_INTERRUPT: begin
                     // Only a lower level may nest afterwards; after level 0 the mask is set to 0, so level 0 may nest again
                     int_accepted <= 1'b1;
                     status_flags_mask[`MASK_MSB:`MASK_LSB] <=
                        (level == 4'h0) ? 4'h0 : level - 4'h1;
                  end
                  `OP_ADVANCE:
                     program_counter <= program_counter + `PC_STEP;
                  `OP_LOAD_MASK:
                     status_flags_mask[`MASK_MSB:`MASK_LSB] <=
                        argument[`MASK_MSB:`MASK_LSB];
                  `OP_LOAD_FLAGS:
                     status_flags_mask[`FLAGS_MSB:`FLAGS_LSB] <=
                        argument[`FLAGS_MSB:`FLAGS_LSB];
                  default: begin
                     result <= result;
                  end
               endcase
            end
         end
      end
   end

endmodule // workspace_register_context

// file: bench/wsctx_props.sv
`timescale 1ns/1ps
`include "wsctx_consts.vh"
module wsctx_props (
   input wire I_CLOCK,
   input wire I_RESET_N,
   input wire [4:0] I_AVS_ADDRESS,
   input wire I_AVS_READ,
   input wire I_AVS_WRITE,
   input wire [31:0] I_AVS_WRITEDATA,
   input wire [3:0] I_AVS_BYTEENABLE,
   input wire [31:0] O_AVS_READDATA,
   input wire O_AVS_WAITREQUEST,
   input wire O_MEM_REQ,
   input wire O_MEM_WE,
   input wire [15:0] O_MEM_ADDR,
   input wire [15:0] O_MEM_WDATA,
   input wire I_MEM_ACK
);
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_RESET_N);
   // Slave is deaf until its synchronised reset copy lets go
   reg [1:0] up;
   reg [15:0] base_seen;
   reg base_known;
   wire go = (up == 2'h3);
   always @(posedge I_CLOCK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         up <= 2'h0;
         base_known <= 1'b0;
         base_seen <= 16'h0000;
      end else begin
         if (!go) up <= up + 2'h1;
         if (I_AVS_WRITE && !O_AVS_WAITREQUEST) begin
            if (I_AVS_ADDRESS == `REG_WORKSPACE_BASE &&
                  I_AVS_BYTEENABLE[1:0] == 2'h3) begin
               base_known <= 1'b1;
               base_seen <= I_AVS_WRITEDATA[15:0];
            end else if (I_AVS_ADDRESS == `REG_WORKSPACE_BASE) begin
               // Partial byte write leaves a merge we do not track
               base_known <= 1'b0;
            end else if (I_AVS_ADDRESS == `REG_COMMAND) begin
               // Commands may switch context, so forget the base
               base_known <= 1'b0;
            end
         end
      end
   end
   property p_wait_pulse;
      !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse)
      else $error("waitrequest low for more than one cycle");
   property p_read_prompt;
      go && I_AVS_READ && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
   endproperty
   a_read_prompt: assert property (p_read_prompt)
      else $error("register read not answered in the next cycle");
   property p_write_bounded;
      go && I_AVS_WRITE && O_AVS_WAITREQUEST |-> ##[1:400] !O_AVS_WAITREQUEST;
   endproperty
   a_write_bounded: assert property (p_write_bounded)
      else $error("register write never completed");
   property p_unmapped;
      go && I_AVS_READ && O_AVS_WAITREQUEST && I_AVS_ADDRESS == 5'h1c
         |=> O_AVS_READDATA == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned nonzero data");
   property p_base_readback;
      base_known && I_AVS_READ && !O_AVS_WAITREQUEST &&
         I_AVS_ADDRESS == `REG_WORKSPACE_BASE
         |-> O_AVS_READDATA == {16'h0000, base_seen};
   endproperty
   a_base_readback: assert property (p_base_readback)
      else $error("workspace base reads back a stale value");
   property p_mem_hold;
      O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ && $stable(O_MEM_ADDR) &&
         $stable(O_MEM_WE) && $stable(O_MEM_WDATA);
   endproperty
   a_mem_hold: assert property (p_mem_hold)
      else $error("memory request changed before acknowledge");
   property p_mem_release;
      O_MEM_REQ && I_MEM_ACK |=> !O_MEM_REQ;
   endproperty
   a_mem_release: assert property (p_mem_release)
      else $error("memory request not released after acknowledge");
   property p_even_word;
      O_MEM_REQ |-> !O_MEM_ADDR[0];
   endproperty
   a_even_word: assert property (p_even_word)
      else $error("memory word address is odd");
   cover property (O_MEM_REQ && O_MEM_WE && I_MEM_ACK);
   cover property (I_AVS_WRITE && O_AVS_WAITREQUEST [*3]);
   cover property (I_AVS_READ && I_AVS_ADDRESS == 5'h1c);
endmodule // wsctx_props

bind workspace_register_context wsctx_props u_props (
   .I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N),
   .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
   .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
   .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
   .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_MEM_REQ(O_MEM_REQ),
   .O_MEM_WE(O_MEM_WE), .O_MEM_ADDR(O_MEM_ADDR),
   .O_MEM_WDATA(O_MEM_WDATA), .I_MEM_ACK(I_MEM_ACK));

// file: bench/wsctx_memory.sv
`timescale 1ns/1ps
module wsctx_memory (
   input wire i_clock,
   input wire [3:0] i_latency,
   input wire i_req,
   input wire i_we,
   input wire [15:0] i_addr,
   input wire [15:0] i_wdata,
   output reg o_ack,
   output reg [15:0] o_rdata
);
   reg [15:0] mem [0:32767];
   reg [3:0] wait_count;
   integer k;
   initial begin
      for (k = 0; k < 32768; k = k + 1) mem[k] = 16'h0000;
      o_ack = 1'b0;
      o_rdata = 16'h0000;
      wait_count = 4'h0;
   end
   always @(posedge i_clock) begin
      o_ack <= 1'b0;
      // Read data never lingers, so a late sample cannot pass
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
         if (wait_count == i_latency) begin
            wait_count <= 4'h0;
            o_ack <= 1'b1;
            if (i_we) mem[i_addr[15:1]] <= i_wdata;
            else o_rdata <= mem[i_addr[15:1]];
         end else begin
            wait_count <= wait_count + 4'h1;
         end
      end
   end
endmodule // wsctx_memory

// file: bench/workspace_register_context_test.sv
`timescale 1ns/1ps
`include "wsctx_consts.vh"
module workspace_register_context_test;
   reg clock = 1'b0;
   reg reset_n = 1'b0;
   reg [4:0] avs_address = 5'h00;
   reg avs_read = 1'b0;
   reg avs_write = 1'b0;
   reg [31:0] avs_writedata = 32'h0;
   reg [3:0] mem_latency = 4'h0;
   reg [31:0] seen;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, mem_req, mem_we, mem_ack;
   wire [15:0] mem_addr, mem_wdata, mem_rdata;
   integer failures = 0;
   integer samples_checked = 0;
   integer r;
   always #50 clock = ~clock;
   workspace_register_context dut (.I_CLOCK(clock), .I_RESET_N(reset_n),
      .I_AVS_ADDRESS(avs_address), .I_AVS_READ(avs_read),
      .I_AVS_WRITE(avs_write), .I_AVS_WRITEDATA(avs_writedata),
      .I_AVS_BYTEENABLE(4'h3), .O_AVS_READDATA(avs_readdata),
      .O_AVS_WAITREQUEST(avs_waitrequest), .O_MEM_REQ(mem_req),
      .O_MEM_WE(mem_we), .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata),
      .I_MEM_ACK(mem_ack), .I_MEM_RDATA(mem_rdata));
   wsctx_memory memory (.i_clock(clock), .i_latency(mem_latency),
      .i_req(mem_req), .i_we(mem_we), .i_addr(mem_addr),
      .i_wdata(mem_wdata), .o_ack(mem_ack), .o_rdata(mem_rdata));
   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   task finish_test;
      begin
         $display("checks %0d, mismatches %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input string name, input [31:0] exp, input [31:0] got);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("wrong value %s: expected %h, seen %h", name, exp, got);
         end
      end
   endtask
   task bus(input rd, input [4:0] a, input [15:0] d);
      integer n;
      begin
         @(posedge clock);
         avs_address <= a;
         avs_read <= rd;
         avs_write <= !rd;
         avs_writedata <= {16'h0000, d};
         n = 0;
         @(posedge clock);
         while (avs_waitrequest !== 1'b0 && n < 500) begin
            n = n + 1;
            @(posedge clock);
         end
         if (n == 500) begin
            chk("bus answer", 32'h0, 32'h1);
            finish_test;
         end
         seen = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask
   task chk_reg(input string name, input [4:0] a, input [15:0] e);
      begin
         bus(1'b1, a, 16'h0000);
         chk(name, {16'h0000, e}, seen);
      end
   endtask
   task chk_mem(input [15:0] a, input [15:0] e);
      chk("memory word", {16'h0000, e}, {16'h0000, memory.mem[a[15:1]]});
   endtask
   task put_mem(input [15:0] a, input [15:0] d);
      memory.mem[a[15:1]] = d;
   endtask
   task cmd(input [3:0] op, input [3:0] wr, input [15:0] arg);
      integer n;
      begin
         bus(1'b0, `REG_ARGUMENT, arg);
         bus(1'b0, `REG_COMMAND, {8'h00, wr, op});
         // Lands while a memory command keeps the engine busy and must stall
         bus(1'b0, `REG_ARGUMENT, arg);
         n = 0;
         seen = 32'h1;
         while (seen[0] !== 1'b0 && n < 100) begin
            bus(1'b1, `REG_ENGINE_STATE, 16'h0000);
            n = n + 1;
         end
         if (n == 100) begin
            chk("engine busy", 32'h0, 32'h1);
            finish_test;
         end
      end
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      repeat (5) @(posedge clock);
      chk_reg("base", `REG_WORKSPACE_BASE, `RST_WORKSPACE_BASE);
      chk_reg("counter", `REG_PROGRAM_COUNTER, `RST_PROGRAM_COUNTER);
      chk_reg("stat", `REG_STATUS_FLAGS_MASK, `RST_STATUS_FLAGS_MASK);
      chk_reg("unmapped", 5'h1c, 16'h0000);
      bus(1'b0, `REG_WORKSPACE_BASE, 16'h0100);
      chk_reg("base", `REG_WORKSPACE_BASE, 16'h0100);
      for (r = 0; r < 16; r = r + 15) begin
         cmd(`OP_WR_ADDRESS, r[3:0], 16'h0000);
         chk_reg("address", `REG_RESULT, 16'h0100 + {r[14:0], 1'b0});
      end
      cmd(`OP_WR_WRITE, `WR_SHIFT, 16'h1235);
      chk_mem(16'h0100, 16'h1235);
      cmd(`OP_SHIFT_COUNT, 4'h0, 16'h0000);
      chk_reg("shift", `REG_RESULT, 16'h0005);
      cmd(`OP_WR_WRITE, `WR_IO_BASE, 16'habcd);
      cmd(`OP_IO_BASE, 4'h0, 16'h0000);
      chk_reg("io base", `REG_RESULT, 16'h05e6);
      cmd(`OP_WR_WRITE, 4'h3, 16'h0010);
      cmd(`OP_WR_READ, 4'h3, 16'h0000);
      chk_reg("register", `REG_RESULT, 16'h0010);
      cmd(`OP_INDEXED, 4'h3, 16'h0100);
      chk_reg("indexed", `REG_RESULT, 16'h0110);
      cmd(`OP_INDEXED, 4'h0, 16'h0100);
      chk_reg("no index", `REG_RESULT, 16'h0100);
      bus(1'b0, `REG_PROGRAM_COUNTER, 16'h2000);
      cmd(`OP_ADVANCE, 4'h0, 16'h0000);
      chk_reg("counter", `REG_PROGRAM_COUNTER, 16'h2002);
      cmd(`OP_BRANCH_LINK, 4'h0, 16'h3000);
      chk_mem(16'h0116, 16'h2002);
      chk_reg("counter", `REG_PROGRAM_COUNTER, 16'h3000);
      cmd(`OP_LOAD_MASK, 4'h0, 16'h0005);
      cmd(`OP_LOAD_FLAGS, 4'h0, 16'ha5f0);
      chk_reg("status", `REG_STATUS_FLAGS_MASK, 16'ha5f5);
      mem_latency <= 4'h3;
      put_mem(16'h0400, 16'h0200);
      put_mem(16'h0402, 16'h5000);
      cmd(`OP_BRANCH_LOAD_CONTEXT, 4'h0, 16'h0400);
      chk_mem(16'h021e, 16'ha5f5);
      chk_mem(16'h021c, 16'h3000);
      chk_mem(16'h021a, 16'h0100);
      chk_reg("base", `REG_WORKSPACE_BASE, 16'h0200);
      chk_reg("counter", `REG_PROGRAM_COUNTER, 16'h5000);
      cmd(`OP_RETURN_CONTEXT, 4'h0, 16'h0000);
      chk_reg("base", `REG_WORKSPACE_BASE, 16'h0100);
      chk_reg("counter", `REG_PROGRAM_COUNTER, 16'h3000);
      chk_reg("status", `REG_STATUS_FLAGS_MASK, 16'ha5f5);
      cmd(`OP_INTERRUPT, 4'h0, 16'h0007);
      chk("engine state", 32'h4, seen);
      chk_reg("base", `REG_WORKSPACE_BASE, 16'h0100);
      put_mem(16'h0010, 16'h0300);
      put_mem(16'h0012, 16'h6000);
      cmd(`OP_INTERRUPT, 4'h0, 16'h0004);
      chk("engine state", 32'h2, seen);
      chk_reg("status", `REG_STATUS_FLAGS_MASK, 16'ha5f3);
      chk_reg("base", `REG_WORKSPACE_BASE, 16'h0300);
      chk_reg("counter", `REG_PROGRAM_COUNTER, 16'h6000);
      chk_mem(16'h031e, 16'ha5f5);
      mem_latency <= 4'h0;
      put_mem(16'hfffc, 16'h0500);
      put_mem(16'hfffe, 16'h7000);
      cmd(`OP_LOAD_RESET, 4'h0, 16'hfffc);
      chk_reg("base", `REG_WORKSPACE_BASE, 16'h0500);
      chk_reg("counter", `REG_PROGRAM_COUNTER, 16'h7000);
      chk_mem(16'h051a, 16'h0300);
      finish_test;
   end
endmodule // workspace_register_context_test
